// ===== fsps_pkg.sv
// Package for the frame and multiframe sync pulse shaper.
// Assumes a 32-bit AHB-Lite bus with one register per aligned word.
package fsps_pkg;

  // Register byte addresses.
  localparam logic [7:0] CFG_ADDR    = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;

  // Field positions in the sync pulse configuration register.
  localparam int SRC_SEL_BIT  = 7;
  localparam int FS_INV_BIT   = 3;
  localparam int FS_PULSE_BIT = 2;
  localparam int MF_INV_BIT   = 1;
  localparam int MF_PULSE_BIT = 0;

  // Reset value and the mask of implemented bits; bits 6..4 read zero.
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_MASK  = 8'h8f;

  // Status register field positions.
  localparam int ST_FS_BIT  = 0;
  localparam int ST_MF_BIT  = 1;
  localparam int ST_C8_BIT  = 2;
  localparam int ST_C2_BIT  = 3;
  localparam int ST_O3_BIT  = 4;

  // Width of the register data and of the decoded address.
  localparam int REG_W  = 8;
  localparam int ADDR_W = 8;

  // Types.
  typedef enum logic [1:0] {
    FSPS_IDLE,
    FSPS_ARMED,
    FSPS_HIGH
  } fsps_pulse_t;

endpackage : fsps_pkg

// ===== fsps_shaper.sv
// One sync output shaper: square wave or one output_three period pulse.
// Assumes the reference and output_three edge are already synchronised.
`timescale 1ns/10ps
module fsps_shaper (
  input  wire logic hclk,      // System clock.
  input  wire logic hresetn,   // Asynchronous reset, active low.
  input  wire logic ce,        // Clock enable, freezes state when low.
  input  wire logic ref_in,    // Selected synchronised reference wave.
  input  wire logic o3_rise,   // One-cycle mark of an output_three edge.
  input  wire logic pulsed,    // High selects the narrow pulse.
  input  wire logic invert,    // High inverts the output.
  output logic      sync_out   // Shaped sync output, registered.
);

  fsps_pkg::fsps_pulse_t st_r, st_nxt;
  logic ref_d_r, ref_d_nxt;
  logic out_r, out_nxt;
  logic wave;

  // The pulse waits for the next output_three edge after the reference
  // rises, then stays high for exactly one output_three period.
  always_comb begin
    ref_d_nxt = ref_in;
    st_nxt    = st_r;
    unique case (st_r)
      fsps_pkg::FSPS_IDLE: begin
        if (ref_in && !ref_d_r) begin
          st_nxt = fsps_pkg::FSPS_ARMED;
        end
      end
      fsps_pkg::FSPS_ARMED: begin
        if (o3_rise) begin
          st_nxt = fsps_pkg::FSPS_HIGH;
        end
      end
      fsps_pkg::FSPS_HIGH: begin
        if (o3_rise) begin
          st_nxt = fsps_pkg::FSPS_IDLE;
        end
      end
      default: st_nxt = fsps_pkg::FSPS_IDLE;
    endcase
    wave    = pulsed ? (st_r == fsps_pkg::FSPS_HIGH) : ref_in;
    out_nxt = wave ^ invert;
  end

  // State registers, frozen while the clock enable is low.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r    <= fsps_pkg::FSPS_IDLE;
      ref_d_r <= 1'b0;
      out_r   <= 1'b0;
    end else if (ce) begin
      st_r    <= st_nxt;
      ref_d_r <= ref_d_nxt;
      out_r   <= out_nxt;
    end
  end

  assign sync_out = out_r;

  // A pulse never lasts beyond the output_three edge that ends it.
  chk_pulse_end: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && st_r == fsps_pkg::FSPS_HIGH && o3_rise |=>
      st_r == fsps_pkg::FSPS_IDLE)
    else $error("pulse did not end at output_three edge");

endmodule : fsps_shaper

// ===== fsps_top.sv
// Frame sync and multiframe sync shaping with an AHB-Lite config port.
// Assumes DPLL waves and output_three arrive asynchronously on pins.
`timescale 1ns/10ps
module fsps_top (
  input  wire logic        hclk,                // System clock, 50 MHz.
  input  wire logic        hresetn,             // Async reset, active low.
  input  wire logic        ce,                  // Clock enable.
  input  wire logic        hsel,                // Slave select.
  input  wire logic [31:0] haddr,               // Byte address.
  input  wire logic [1:0]  htrans,              // Transfer type.
  input  wire logic        hwrite,              // Write when high.
  input  wire logic [2:0]  hsize,               // Transfer size.
  input  wire logic [31:0] hwdata,              // Write data.
  input  wire logic        hready,              // Bus ready in.
  output logic      [31:0] hrdata,              // Read data.
  output logic             hreadyout,           // Slave ready.
  output logic             hresp,               // Always OKAY.
  input  wire logic        primary_8k_in,       // Primary DPLL 8 kHz.
  input  wire logic        primary_2k_in,       // Primary DPLL 2 kHz.
  input  wire logic        auxiliary_8k_in,     // Auxiliary DPLL 8 kHz.
  input  wire logic        auxiliary_2k_in,     // Auxiliary DPLL 2 kHz.
  input  wire logic        output_three_in,     // output_three clock.
  output logic             frame_sync_out,      // Shaped 8 kHz sync.
  output logic             multiframe_sync_out, // Shaped 2 kHz sync.
  output logic             clk_8k_out,          // 8 kHz to clock outputs.
  output logic             clk_2k_out           // 2 kHz to clock outputs.
);

  // Synchroniser stages for the five pin inputs.
  logic [4:0] meta_r, meta_nxt;
  logic [4:0] sync_r, sync_nxt;
  logic       o3_d_r, o3_d_nxt;
  logic       o3_rise;

  // Bus slave state.
  logic [fsps_pkg::REG_W-1:0]  cfg_r, cfg_nxt;
  logic                        wr_pend_r, wr_pend_nxt;
  logic [fsps_pkg::ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
  logic [31:0]                 rdata_r, rdata_nxt;
  logic                        ready_r, ready_nxt;

  // Selected waves and registered clock outputs.
  logic sel8, sel2;
  logic c8_r, c8_nxt;
  logic c2_r, c2_nxt;
  logic fs_w, mf_w;
  logic addr_ok;
  logic [fsps_pkg::ADDR_W-1:0] a_addr;

  // Two-flop synchronisers; only the second stage is read by logic.
  always_comb begin
    meta_nxt = {output_three_in, auxiliary_2k_in, auxiliary_8k_in,
                primary_2k_in, primary_8k_in};
    sync_nxt = meta_r;
    o3_d_nxt = sync_r[4];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= 5'h00;
      sync_r <= 5'h00;
      o3_d_r <= 1'b0;
    end else if (ce) begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      o3_d_r <= o3_d_nxt;
    end
  end

  assign o3_rise = sync_r[4] && !o3_d_r;

  // Source selection for both sync outputs and the clock outputs.
  assign sel8 = cfg_r[fsps_pkg::SRC_SEL_BIT] ? sync_r[2]
                                             : sync_r[0];
  assign sel2 = cfg_r[fsps_pkg::SRC_SEL_BIT] ? sync_r[3]
                                             : sync_r[1];

  // Address decode of a valid transfer in its address phase.
  assign a_addr  = haddr[fsps_pkg::ADDR_W-1:0];
  assign addr_ok = hsel && htrans[1] && hready;

  // Bus slave: zero wait states, write data taken in the data phase,
  // read data prepared at the address phase so it comes from a flop.
  always_comb begin
    cfg_nxt     = cfg_r;
    wr_pend_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    rdata_nxt   = rdata_r;
    ready_nxt   = 1'b1;
    c8_nxt      = sel8;
    c2_nxt      = sel2;
    if (wr_pend_r && wr_addr_r == fsps_pkg::CFG_ADDR) begin
      cfg_nxt = hwdata[fsps_pkg::REG_W-1:0] & fsps_pkg::CFG_MASK;
    end
    if (addr_ok) begin
      wr_pend_nxt = hwrite;
      wr_addr_nxt = a_addr;
      rdata_nxt   = 32'h0000_0000;
      if (!hwrite) begin
        if (a_addr == fsps_pkg::CFG_ADDR) begin
          // A read right behind a write sees the value being written.
          rdata_nxt[fsps_pkg::REG_W-1:0] = cfg_nxt;
        end else if (a_addr == fsps_pkg::STATUS_ADDR) begin
          rdata_nxt[fsps_pkg::ST_FS_BIT] = fs_w;
          rdata_nxt[fsps_pkg::ST_MF_BIT] = mf_w;
          rdata_nxt[fsps_pkg::ST_C8_BIT] = c8_r;
          rdata_nxt[fsps_pkg::ST_C2_BIT] = c2_r;
          rdata_nxt[fsps_pkg::ST_O3_BIT] = sync_r[4];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r     <= fsps_pkg::CFG_RESET;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r   <= 32'h0000_0000;
      ready_r   <= 1'b0;
      c8_r      <= 1'b0;
      c2_r      <= 1'b0;
    end else if (ce) begin
      cfg_r     <= cfg_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r   <= rdata_nxt;
      ready_r   <= ready_nxt;
      c8_r      <= c8_nxt;
      c2_r      <= c2_nxt;
    end
  end

  assign hrdata     = rdata_r;
  assign hreadyout  = ready_r;
  assign hresp      = 1'b0;
  assign clk_8k_out = c8_r;
  assign clk_2k_out = c2_r;

  // Frame sync shaper on the selected 8 kHz wave.
  fsps_shaper u_frame (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .ref_in   (sel8),
    .o3_rise  (o3_rise),
    .pulsed   (cfg_r[fsps_pkg::FS_PULSE_BIT]),
    .invert   (cfg_r[fsps_pkg::FS_INV_BIT]),
    .sync_out (fs_w)
  );

  // Multiframe sync shaper on the selected 2 kHz wave.
  fsps_shaper u_multi (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .ref_in   (sel2),
    .o3_rise  (o3_rise),
    .pulsed   (cfg_r[fsps_pkg::MF_PULSE_BIT]),
    .invert   (cfg_r[fsps_pkg::MF_INV_BIT]),
    .sync_out (mf_w)
  );

  assign frame_sync_out      = fs_w;
  assign multiframe_sync_out = mf_w;

  // Clock output follows the wave of the selected DPLL one cycle later.
  chk_src_select: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && $past(ce) && $stable(cfg_r) |->
      clk_8k_out == ($past(cfg_r[7]) ? $past(sync_r[2]) : $past(sync_r[0])))
    else $error("8 kHz clock output not from selected DPLL");

  // Square mode frame sync is the selected wave with the chosen polarity.
  chk_fs_invert: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && $past(ce) && $stable(cfg_r) && !cfg_r[2] |->
      frame_sync_out == ($past(sel8) ^ cfg_r[3]))
    else $error("frame sync polarity wrong");

  // In pulsed mode frame sync changes only two cycles after an o3 edge.
  // The output lags the register by one cycle, so the configuration
  // must have held for two cycles before a change is judged.
  chk_fs_pulse_edge: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && $past(ce) && $past(ce, 2) && $stable(cfg_r)
      && cfg_r == $past(cfg_r, 2) && cfg_r[2]
      && $changed(frame_sync_out) |-> $past(o3_rise, 2))
    else $error("frame sync pulse edge not on output_three edge");

  // A non-inverted frame pulse rises then falls on consecutive o3 edges.
  chk_fs_pulse_width: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && cfg_r[2] && !cfg_r[3] && $rose(frame_sync_out) |=>
      (frame_sync_out || $past(o3_rise, 2)))
    else $error("frame sync pulse ended early");

  // Square mode multiframe sync is the selected wave with its polarity.
  chk_mf_invert: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && $past(ce) && $stable(cfg_r) && !cfg_r[0] |->
      multiframe_sync_out == ($past(sel2) ^ cfg_r[1]))
    else $error("multiframe sync polarity wrong");

  // In pulsed mode multiframe sync moves only after an o3 edge, judged
  // once the configuration has held for two cycles.
  chk_mf_pulse_edge: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && $past(ce) && $past(ce, 2) && $stable(cfg_r)
      && cfg_r == $past(cfg_r, 2) && cfg_r[0]
      && $changed(multiframe_sync_out) |-> $past(o3_rise, 2))
    else $error("multiframe pulse edge not on output_three edge");

  // Configuration reads zero while reset is applied.
  chk_cfg_reset: assert property (@(posedge hclk)
    !hresetn |-> cfg_r == 8'h00)
    else $error("config not zero in reset");

endmodule : fsps_top

// ===== fsps_sync_model.sv
// Far-side model: DPLL reference waves and the output_three clock.
// Assumes a 20 ns bench clock; 8 kHz is scaled to 256 cycles of it.
`timescale 1ns/10ps
module fsps_sync_model (
  input  wire logic o3_en, // Software has enabled output_three.
  output logic      p8,    // Primary DPLL 8 kHz wave.
  output logic      p2,    // Primary DPLL 2 kHz wave.
  output logic      a8,    // Auxiliary DPLL 8 kHz wave.
  output logic      a2,    // Auxiliary DPLL 2 kHz wave.
  output logic      o3     // output_three clock.
);
  // The waves start off the clock edge so each crossing is clean.
  initial begin
    p8 = 1'b0;
    #7;
    forever #2560 p8 = ~p8;
  end
  initial begin
    p2 = 1'b0;
    #7;
    forever #10240 p2 = ~p2;
  end
  initial begin
    a8 = 1'b0;
    #13;
    forever #1920 a8 = ~a8;
  end
  initial begin
    a2 = 1'b0;
    #13;
    forever #7680 a2 = ~a2;
  end
  // The clock stands still low until software enables it.
  initial begin
    o3 = 1'b0;
    #3;
    forever begin
      #160;
      o3 = o3_en ? ~o3 : 1'b0;
    end
  end
endmodule : fsps_sync_model

// ===== frame_sync_pulse_shaper_test.sv
// Bench for the sync pulse shaper: bus tasks and hand-written scenarios.
// Assumes fsps_pkg, fsps_top and fsps_sync_model are compiled first.
`timescale 1ns/10ps
module frame_sync_pulse_shaper_test;
  logic        hclk, hresetn, hsel, hwrite, o3_en, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic        p8, p2, a8, a2, o3, fs, mf, c8, c2;
  int          error_cnt, checked;
  int          cyc = 0;

  // Clock, and a ceiling on the run length.
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      end_sim();
    end
  end

  fsps_sync_model i_src (.o3_en(o3_en), .p8(p8), .p2(p2), .a8(a8),
                         .a2(a2), .o3(o3));
  fsps_top i_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .primary_8k_in(p8),
    .primary_2k_in(p2), .auxiliary_8k_in(a8), .auxiliary_2k_in(a2),
    .output_three_in(o3), .frame_sync_out(fs), .multiframe_sync_out(mf),
    .clk_8k_out(c8), .clk_2k_out(c2));

  // Compares one value and counts it.
  task automatic check(input string nm, input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : check

  // One single AHB-Lite transfer; waits for hready in both phases.
  task automatic bus(input logic wr, input logic [31:0] a, d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : bus

  task automatic cfg(input logic [7:0] v);
    logic [31:0] q;
    bus(1'b1, {24'h0, fsps_pkg::CFG_ADDR}, {24'h0, v}, q);
  endtask : cfg

  function automatic logic pick(input int i);
    case (i)
      0: pick = fs;
      1: pick = mf;
      2: pick = c8;
      default: pick = c2;
    endcase
  endfunction : pick

  // Length of one whole run at level lv and of the run after it.
  task automatic runs(input int i, input logic lv, output int a, b);
    a = 0;
    b = 0;
    repeat (16) @(posedge hclk);
    while (pick(i) === lv) @(posedge hclk);
    while (pick(i) !== lv) @(posedge hclk);
    while (pick(i) === lv) begin
      a++;
      @(posedge hclk);
    end
    while (pick(i) !== lv) begin
      b++;
      @(posedge hclk);
    end
  endtask : runs

  // Reset value, implemented bits and an unmapped address.
  task automatic t_regs();
    logic [31:0] q;
    bus(1'b0, {24'h0, fsps_pkg::CFG_ADDR}, 32'h0, q);
    check("cfg reset", q, {24'h0, fsps_pkg::CFG_RESET});
    cfg(8'hff);
    bus(1'b0, {24'h0, fsps_pkg::CFG_ADDR}, 32'h0, q);
    check("cfg bits", q, {24'h0, fsps_pkg::CFG_MASK});
    bus(1'b0, 32'h8, 32'h0, q);
    check("unmapped", q, 32'h0);
  endtask : t_regs

  // Each source shows its own period on both clock outputs and on frame sync.
  task automatic t_source();
    int a, b;
    for (int s = 0; s < 2; s++) begin
      cfg(8'(s << fsps_pkg::SRC_SEL_BIT));
      runs(2, 1'b1, a, b);
      check("clk_8k period", a + b, s ? 192 : 256);
      runs(3, 1'b1, a, b);
      check("clk_2k period", a + b, s ? 768 : 1024);
      runs(0, 1'b1, a, b);
      check("frame period", a + b, s ? 192 : 256);
    end
  endtask : t_source

  // Square waves, then the level just after a reference rise.
  task automatic t_square();
    int          a, b;
    logic [31:0] q;
    cfg(8'h00);
    runs(0, 1'b1, a, b);
    check("frame high", a, 128);
    runs(1, 1'b1, a, b);
    check("multi high", a, 512);
    for (int v = 0; v < 2; v++) begin
      cfg(v ? 8'h0a : 8'h00);
      @(posedge p8);
      repeat (8) @(posedge hclk);
      check("frame level", fs, v == 0);
      bus(1'b0, {24'h0, fsps_pkg::STATUS_ADDR}, 32'h0, q);
      check("status frame", q[fsps_pkg::ST_FS_BIT], v == 0);
      @(posedge p2);
      repeat (8) @(posedge hclk);
      check("multi level", mf, v == 0);
    end
  endtask : t_square

  // Pulses one output_three period wide, plain and inverted.
  task automatic t_pulse();
    int a, b;
    o3_en <= 1'b1;
    cfg(8'h05);
    runs(0, 1'b1, a, b);
    check("frame pulse", a, 16);
    check("pulse period", a + b, 256);
    runs(1, 1'b1, a, b);
    check("multi pulse", a, 16);
    cfg(8'h0f);
    runs(0, 1'b0, a, b);
    check("frame inv pulse", a, 16);
    runs(1, 1'b0, a, b);
    check("multi inv pulse", a, 16);
  endtask : t_pulse

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  // Main sequence.
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    haddr = 32'h0;
    hwdata = 32'h0;
    o3_en = 1'b0;
    error_cnt = 0;
    checked = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_source();
    t_square();
    t_pulse();
    end_sim();
  end
endmodule : frame_sync_pulse_shaper_test
